/* File: verilog/rtc_pkg.sv */
// rtc_pkg: register map, field layout, reset values and timing constants
// for the real-time clock with latched time reads and interrupts.
// assumes: one 40 MHz system clock; 8-bit register port.
package rtc_pkg;

	// -------------------------------------------------------------------
	// timing
	// -------------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned HUNDREDTH_NS    = 10_000_000;
	localparam int unsigned HUNDREDTH_CYC   =
		(CLK_HZ / 1000) * (HUNDREDTH_NS / 1000) / 1000;

	// -------------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------------
	localparam logic [4:0] ADDR_HUNDREDTHS  = 5'h00;
	localparam logic [4:0] ADDR_TIME_LAST   = 5'h07;
	localparam logic [4:0] ADDR_ALARM_FIRST = 5'h08;
	localparam logic [4:0] ADDR_ALARM_LAST  = 5'h0f;
	localparam logic [4:0] ADDR_INT_MASK    = 5'h10; // write: mask
	localparam logic [4:0] ADDR_INT_STATUS  = 5'h10; // read: status
	localparam logic [4:0] ADDR_COMMAND     = 5'h11;

	// time field index (same as offset, alarm is offset minus 8)
	localparam int unsigned F_HUND  = 0;
	localparam int unsigned F_HOUR  = 1;
	localparam int unsigned F_MIN   = 2;
	localparam int unsigned F_SEC   = 3;
	localparam int unsigned F_MONTH = 4;
	localparam int unsigned F_DATE  = 5;
	localparam int unsigned F_YEAR  = 6;
	localparam int unsigned F_DAY   = 7;
	localparam int unsigned N_FIELDS = 8;

	// status / mask bit positions
	localparam int unsigned B_ALARM  = 0;
	localparam int unsigned B_HUND   = 1;
	localparam int unsigned B_TENTH  = 2;
	localparam int unsigned B_SEC    = 3;
	localparam int unsigned B_MIN    = 4;
	localparam int unsigned B_HOUR   = 5;
	localparam int unsigned B_DAY    = 6;
	localparam int unsigned B_ANY    = 7;

	// alarm entry: this bit set means the field is ignored (hundredths: must be zero)
	localparam int unsigned ALARM_MASK_BIT = 7;

	// command register fields
	localparam int unsigned C_FREQ_LO = 0;
	localparam int unsigned C_FREQ_HI = 1;
	localparam int unsigned C_RUN     = 3;
	localparam int unsigned C_INT_EN  = 4;
	localparam int unsigned C_TEST    = 5;

	// reset values
	localparam logic [7:0] RST_MASK    = 8'h00;
	localparam logic [7:0] RST_STATUS  = 8'h00;
	localparam logic [7:0] RST_COMMAND = 8'h00;
	localparam logic [7:0] RST_ALARM   = 8'h00;
	localparam logic [7:0] RST_ONE     = 8'h01; // month and date
	localparam logic [7:0] RST_ZERO    = 8'h00;

	// counter limits
	localparam logic [7:0] MAX_HUND  = 8'h63; // 99
	localparam logic [7:0] MAX_SEC   = 8'h3b; // 59
	localparam logic [7:0] MAX_HOUR  = 8'h17; // 23
	localparam logic [7:0] MAX_MONTH = 8'h0c; // 12
	localparam logic [7:0] MAX_YEAR  = 8'h63; // 99
	localparam logic [7:0] MAX_DAY   = 8'h06; // 0..6

endpackage

/* File: verilog/alarm_compare.sv */
// alarm_compare: matches alarm storage against the live time counters.
// assumes: fields packed by index, alarm bit 7 set means field ignored, except hundredths, which must then be zero.
`timescale 1ns/1ps
module alarm_compare (
	input  wire logic [7:0][7:0] time_in,  // live counters
	input  wire logic [7:0][7:0] alarm_in, // alarm storage
	output logic                 match_out // all unmasked fields equal, masked hundredths at zero
);
	import rtc_pkg::*;

	logic [7:0] field_ok;

	// -------------------------------------------------------------------
	// per-field compare
	// -------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_field
			if (g == F_HUND) begin : g_hund
				// masked hundredths counts as zero, not as don't-care
				assign field_ok[g] = alarm_in[g][ALARM_MASK_BIT] ?
					(time_in[g] == RST_ZERO) :
					(time_in[g] == alarm_in[g]); // RULE15
			end else begin : g_other
				assign field_ok[g] = alarm_in[g][ALARM_MASK_BIT] ||
					(time_in[g] == alarm_in[g]); // RULE14
			end
		end
	endgenerate

	assign match_out = &field_ok;

endmodule

/* File: verilog/rtc_core.sv */
// rtc_core: time counters, read latching, alarm and periodic interrupts.
// assumes: register master on sys_clk_in, one-cycle strobes, data read
// back the cycle after the read strobe.
//
// Functional notes
// RULE1 - reading hundredths captures the other seven time counters
// RULE2 - hundredths value comes live from its counter, never latched
// RULE3 - time registers return the snapshot until hundredths read again
// RULE4 - host reads hundredths first, then the other time registers
// RULE5 - alarm storage and other ram reads are direct, never latched
// RULE6 - status records every counter advance regardless of mask
// RULE7 - status read clears all bits right after returning them
// RULE8 - bit 7 marks any interrupt, bit 0 marks alarm source
// RULE9 - status read releases the interrupt output
// RULE10 - periodic needs global enable and a mask bit in 1..6
// RULE11 - periodic fires on each increment of a selected counter
// RULE12 - alarm needs global enable and mask bit 0
// RULE13 - alarm match sets status bits 0 and 7 and drives output
// RULE14 - alarm compare ignores masked fields
// RULE15 - masked hundredths alarm behaves as if it held zero
// RULE16 - host isr reads status to release and identify source
// RULE17 - mask at 0x10, command register at 0x11
// RULE18 - mask 0x08 selects one-second periodic interrupt only
// RULE19 - status bits 1..6 sit where the periodic mask bits sit
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module rtc_core #(
	parameter int unsigned TICK_CYCLES = rtc_pkg::HUNDREDTH_CYC
) (
	input  wire logic       sys_clk_in,   // 40 MHz system clock
	input  wire logic       reset_in,     // async reset, active high
	input  wire logic [4:0] addr_in,      // register address
	input  wire logic [7:0] wr_data_in,   // write data
	input  wire logic       wr_in,        // write strobe
	input  wire logic       rd_in,        // read strobe
	output logic      [7:0] rd_data_out,  // read data, cycle after rd_in
	output logic            irq_out,      // level interrupt, high active
	output logic            int_pin_out,  // open-drain pin level (0)
	output logic            int_pin_oe_out // open-drain pin enable
);
	import rtc_pkg::*;

	// -------------------------------------------------------------------
	// state
	// -------------------------------------------------------------------
	logic [7:0][7:0] time_reg,  time_next;
	logic [7:0][7:0] latch_reg, latch_next;
	logic [7:0][7:0] alarm_reg, alarm_next;
	logic [7:0]      mask_reg,  mask_next;
	logic [7:0]      status_reg, status_next;
	logic [7:0]      command_reg, command_next;
	logic [7:0]      rd_data_reg, rd_data_next;
	logic            irq_reg,   irq_next;
	logic            tick_d_reg, tick_d_next;
	logic [31:0]     pre_reg,   pre_next;

	logic            tick;
	logic [6:1]      adv;
	logic            match;
	logic            alarm_fire;
	logic            periodic_fire;
	logic            status_rd;
	logic            int_en;

	assign int_en    = command_reg[C_INT_EN];
	assign status_rd = rd_in && (addr_in == ADDR_INT_STATUS);

	// -------------------------------------------------------------------
	// hundredths time base
	// -------------------------------------------------------------------
	always_comb begin
		pre_next = pre_reg;
		tick     = 1'b0;
		if (command_reg[C_TEST] && command_reg[C_RUN]) begin
			// test mode drives the hundredths counter every clock
			tick     = 1'b1;
			pre_next = 32'h0;
		end else if (command_reg[C_RUN]) begin
			if (pre_reg >= TICK_CYCLES - 1) begin
				pre_next = 32'h0;
				tick     = 1'b1;
			end else begin
				pre_next = pre_reg + 32'h1;
			end
		end
	end

	// -------------------------------------------------------------------
	// calendar counters
	// -------------------------------------------------------------------
	function automatic logic [7:0] month_days(input logic [7:0] m,
						  input logic [7:0] y);
		case (m)
			8'h02:   month_days = (y[1:0] == 2'b00) ? 8'h1d : 8'h1c;
			8'h04, 8'h06, 8'h09, 8'h0b:
				month_days = 8'h1e;
			default: month_days = 8'h1f;
		endcase
	endfunction

	always_comb begin
		time_next = time_reg;
		adv       = '0;
		if (tick) begin
			adv[B_HUND] = 1'b1;
			if (time_reg[F_HUND] % 8'h0a == 8'h09)
				adv[B_TENTH] = 1'b1;
			time_next[F_HUND] = time_reg[F_HUND] + 8'h01;
			if (time_reg[F_HUND] >= MAX_HUND) begin
				time_next[F_HUND] = RST_ZERO;
				adv[B_SEC] = 1'b1;
				time_next[F_SEC] = time_reg[F_SEC] + 8'h01;
				if (time_reg[F_SEC] >= MAX_SEC) begin
					time_next[F_SEC] = RST_ZERO;
					adv[B_MIN] = 1'b1;
					time_next[F_MIN] = time_reg[F_MIN] + 8'h01;
					if (time_reg[F_MIN] >= MAX_SEC) begin
						time_next[F_MIN] = RST_ZERO;
						adv[B_HOUR] = 1'b1;
						time_next[F_HOUR] = time_reg[F_HOUR] + 8'h01;
						if (time_reg[F_HOUR] >= MAX_HOUR) begin
							time_next[F_HOUR] = RST_ZERO;
							adv[B_DAY] = 1'b1;
						end
					end
				end
			end
			if (adv[B_DAY]) begin
				time_next[F_DAY] = (time_reg[F_DAY] >= MAX_DAY) ?
					RST_ZERO : time_reg[F_DAY] + 8'h01;
				time_next[F_DATE] = time_reg[F_DATE] + 8'h01;
				if (time_reg[F_DATE] >= month_days(time_reg[F_MONTH],
						time_reg[F_YEAR])) begin
					time_next[F_DATE]  = RST_ONE;
					time_next[F_MONTH] = time_reg[F_MONTH] + 8'h01;
					if (time_reg[F_MONTH] >= MAX_MONTH) begin
						time_next[F_MONTH] = RST_ONE;
						time_next[F_YEAR] =
							(time_reg[F_YEAR] >= MAX_YEAR) ?
							RST_ZERO : time_reg[F_YEAR] + 8'h01;
					end
				end
			end
		end
		// a host write wins over a simultaneous count
		if (wr_in && (addr_in <= ADDR_TIME_LAST))
			time_next[addr_in[2:0]] = wr_data_in;
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			pre_reg  <= 32'h0;
			time_reg <= {RST_ZERO, RST_ZERO, RST_ONE, RST_ONE,
				     RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
		end else begin
			pre_reg  <= pre_next;
			time_reg <= time_next;
		end
	end

	// -------------------------------------------------------------------
	// alarm compare
	// -------------------------------------------------------------------
	alarm_compare u_alarm (
		.time_in   (time_reg),
		.alarm_in  (alarm_reg),
		.match_out (match)
	);

	// evaluated once, the cycle after each count, so a match fires once
	assign alarm_fire    = tick_d_reg && match &&
			       int_en && mask_reg[B_ALARM]; // RULE12 RULE13
	assign periodic_fire = int_en &&
			       |(adv & mask_reg[B_DAY:B_HUND]); // RULE10 RULE11 RULE18

	// -------------------------------------------------------------------
	// registers, status and interrupt
	// -------------------------------------------------------------------
	always_comb begin
		latch_next   = latch_reg;
		alarm_next   = alarm_reg;
		mask_next    = mask_reg;
		command_next = command_reg;
		rd_data_next = 8'h00;
		tick_d_next  = tick;

		if (wr_in) begin
			if (addr_in >= ADDR_ALARM_FIRST && addr_in <= ADDR_ALARM_LAST)
				alarm_next[addr_in[2:0]] = wr_data_in;
			if (addr_in == ADDR_INT_MASK)
				mask_next = wr_data_in; // RULE17
			if (addr_in == ADDR_COMMAND)
				command_next = wr_data_in; // RULE17
		end

		if (rd_in) begin
			if (addr_in == ADDR_HUNDREDTHS) begin
				rd_data_next = time_reg[F_HUND]; // RULE2
				latch_next   = time_reg; // RULE1
			end else if (addr_in <= ADDR_TIME_LAST) begin
				rd_data_next = latch_reg[addr_in[2:0]]; // RULE3 RULE4
			end else if (addr_in <= ADDR_ALARM_LAST) begin
				rd_data_next = alarm_reg[addr_in[2:0]]; // RULE5
			end else if (addr_in == ADDR_INT_STATUS) begin
				rd_data_next = status_reg;
			end else if (addr_in == ADDR_COMMAND) begin
				rd_data_next = command_reg;
			end
		end

		// clear on read, but an event in the same cycle survives
		status_next = status_rd ? RST_STATUS : status_reg; // RULE7
		status_next[B_DAY:B_HUND] =
			status_next[B_DAY:B_HUND] | adv; // RULE6 RULE19
		if (alarm_fire) begin
			status_next[B_ALARM] = 1'b1; // RULE8 RULE13
			status_next[B_ANY]   = 1'b1;
		end
		if (periodic_fire)
			status_next[B_ANY] = 1'b1; // RULE8

		irq_next = (status_rd ? 1'b0 : irq_reg) ||
			   alarm_fire || periodic_fire; // RULE9 RULE16
	end

	always_ff @(posedge sys_clk_in or posedge reset_in) begin
		if (reset_in) begin
			latch_reg   <= '0;
			alarm_reg   <= {8{RST_ALARM}};
			mask_reg    <= RST_MASK;
			command_reg <= RST_COMMAND;
			status_reg  <= RST_STATUS;
			rd_data_reg <= 8'h00;
			irq_reg     <= 1'b0;
			tick_d_reg  <= 1'b0;
		end else begin
			latch_reg   <= latch_next;
			alarm_reg   <= alarm_next;
			mask_reg    <= mask_next;
			command_reg <= command_next;
			status_reg  <= status_next;
			rd_data_reg <= rd_data_next;
			irq_reg     <= irq_next;
			tick_d_reg  <= tick_d_next;
		end
	end

	assign rd_data_out    = rd_data_reg;
	assign irq_out        = irq_reg;
	assign int_pin_out    = 1'b0;
	assign int_pin_oe_out = irq_reg; // RULE13

endmodule

/* File: bench/host_model.sv */
// host_model: host processor on the 8-bit register port.
// assumes: device samples strobes on the rising edge of sys_clk_in.
`timescale 1ns/1ps
module host_model (
	input  wire logic       sys_clk_in,  // system clock
	input  wire logic [7:0] rd_data_in,  // read data
	output logic      [4:0] addr_out,    // address
	output logic      [7:0] wr_data_out, // write data
	output logic            wr_out,      // write strobe
	output logic            rd_out       // read strobe
);
	initial begin
		addr_out = 5'h00;
		wr_data_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		wr_data_out <= d;
		wr_out <= 1'b1;
		@(posedge sys_clk_in);
		wr_out <= 1'b0;
		// released data shows the inverse, not a stale copy
		wr_data_out <= ~d;
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge sys_clk_in);
		rd_out <= 1'b0;
		#1;
		d = rd_data_in;
	endtask
	// hundredths first, so the rest comes from one snapshot
	task automatic rd_time(output logic [7:0] t [8]);
		for (int i = 0; i < 8; i++)
			rd_reg(5'(i), t[i]);
	endtask
endmodule

/* File: bench/rtc_core_chk.sv */
// rtc_core_chk: port assertions for read data and the interrupt output.
// assumes: bound into every rtc_core instance.
`timescale 1ns/1ps
module rtc_core_chk #(
	parameter int unsigned TICK_CYCLES = 8
) (
	input wire logic       sys_clk_in,    // clock
	input wire logic       reset_in,      // async reset
	input wire logic [4:0] addr_in,       // address
	input wire logic [7:0] wr_data_in,    // write data
	input wire logic       wr_in,         // write strobe
	input wire logic       rd_in,         // read strobe
	input wire logic [7:0] rd_data_out,   // read data
	input wire logic       irq_out,       // interrupt
	input wire logic       int_pin_out,   // pin level
	input wire logic       int_pin_oe_out // pin enable
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	sequence status_rd;
		rd_in && addr_in == 5'h10;
	endsequence
	sequence status_back;
		status_rd ##1 rd_data_out[0];
	endsequence
	idle_data_a: assert property (!rd_in |=> rd_data_out == 8'h00)
		else $error("read data not zero outside read");
	unmapped_zero_a: assert property (
		rd_in && addr_in > 5'h11 |=> rd_data_out == 8'h00)
		else $error("unmapped read not zero");
	pin_follow_a: assert property (int_pin_oe_out == irq_out)
		else $error("pin enable differs from irq");
	pin_low_a: assert property (int_pin_out == 1'b0)
		else $error("open drain pin drives high");
	alarm_any_a: assert property (status_back |-> rd_data_out[7])
		else $error("alarm status without any bit");
	irq_flag_a: assert property (
		rd_in && addr_in == 5'h10 && irq_out |=> rd_data_out[7])
		else $error("irq high but status bit 7 clear");
	irq_hold_a: assert property (
		irq_out && !(rd_in && addr_in == 5'h10) |=> irq_out)
		else $error("irq dropped without status read");
	irq_fall_a: assert property (
		$fell(irq_out) |-> $past(rd_in && addr_in == 5'h10))
		else $error("irq fell without status read");
endmodule
bind rtc_core rtc_core_chk #(.TICK_CYCLES(TICK_CYCLES)) rtc_core_chk_inst (
	.sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in),
	.wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
	.rd_data_out(rd_data_out), .irq_out(irq_out),
	.int_pin_out(int_pin_out), .int_pin_oe_out(int_pin_oe_out));

/* File: bench/tb.sv */
// tb: self-checking bench for rtc_core driven through host_model.
// assumes: short hundredth tick so rollovers come within a few cycles.
`timescale 1ns/1ps
module tb;
	localparam int unsigned TICK = 8;
	logic       sys_clk_in = 1'b0;
	logic       reset_in = 1'b1;
	logic [4:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       irq;
	logic       pin;
	logic       pin_oe;
	int         failures = 0;
	int         check_count = 0;
	int         cycles = 0;
	always #12.5 sys_clk_in = ~sys_clk_in;
	rtc_core #(.TICK_CYCLES(TICK)) rtc_core_inst (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr),
		.wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata),
		.irq_out(irq), .int_pin_out(pin), .int_pin_oe_out(pin_oe));
	host_model host_model_inst (
		.sys_clk_in(sys_clk_in), .rd_data_in(rdata), .addr_out(addr),
		.wr_data_out(wdata), .wr_out(wr), .rd_out(rd));
	task automatic stop_test;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task automatic put_reg(input logic [4:0] a, input logic [7:0] d);
		host_model_inst.wr_reg(a, d);
	endtask
	task automatic get_reg(input logic [4:0] a, input logic [7:0] e,
			input logic [7:0] m = 8'hff);
		logic [7:0] d;
		host_model_inst.rd_reg(a, d);
		chk8(d & m, e);
	endtask
	task automatic wait_irq(input int lim, output int n);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge sys_clk_in);
			#1;
			n++;
		end
	endtask
	task automatic reset_dut;
		reset_in <= 1'b1;
		repeat (4) @(posedge sys_clk_in);
		reset_in <= 1'b0;
	endtask
	task automatic t_reset;
		logic [7:0] t [8];
		host_model_inst.rd_time(t);
		for (int i = 0; i < 8; i++)
			chk8(t[i], (i == 4 || i == 5) ? 8'h01 : 8'h00);
		get_reg(5'h11, 8'h00);
		get_reg(5'h10, 8'h00);
		get_reg(5'h12, 8'h00);
	endtask
	task automatic t_latch;
		logic [7:0] d;
		put_reg(5'h00, 8'h62);
		put_reg(5'h03, 8'h3b);
		put_reg(5'h02, 8'h02);
		get_reg(5'h00, 8'h62);
		put_reg(5'h11, 8'h08);
		repeat (48) @(posedge sys_clk_in);
		get_reg(5'h03, 8'h3b);
		host_model_inst.rd_reg(5'h00, d);
		chk1(d > 8'h00 && d < 8'h08, 1'b1);
		get_reg(5'h03, 8'h00);
		get_reg(5'h02, 8'h03);
		put_reg(5'h08, 8'h85);
		get_reg(5'h08, 8'h85);
	endtask
	task automatic t_periodic;
		int n;
		longint t0;
		reset_dut();
		put_reg(5'h11, 8'h08);
		repeat (20) @(posedge sys_clk_in);
		get_reg(5'h10, 8'h02, 8'h82);
		put_reg(5'h10, 8'h02);
		repeat (20) @(posedge sys_clk_in);
		#1;
		chk1(irq, 1'b0);
		put_reg(5'h11, 8'h18);
		wait_irq(20, n);
		chk1(irq, 1'b1);
		get_reg(5'h10, 8'h82, 8'h82);
		chk1(irq, 1'b0);
		get_reg(5'h10, 8'h00, 8'h81);
		wait_irq(20, n);
		t0 = $time;
		get_reg(5'h10, 8'h82, 8'h82);
		wait_irq(20, n);
		chk1($time - t0 == TICK * 25, 1'b1);
		put_reg(5'h10, 8'h08);
		get_reg(5'h10, 8'h80, 8'h80);
		put_reg(5'h00, 8'h5e);
		wait_irq(100, n);
		chk1(n > 32, 1'b1);
		get_reg(5'h10, 8'h8a, 8'h8b);
	endtask
	task automatic t_alarm;
		int n;
		reset_dut();
		for (int i = 8; i < 16; i++)
			put_reg(5'(i), (i == 11) ? 8'h01 : 8'h80);
		put_reg(5'h00, 8'h50);
		put_reg(5'h10, 8'h01);
		put_reg(5'h11, 8'h18);
		wait_irq(400, n);
		chk1(n > 100, 1'b1);
		chk1(irq, 1'b1);
		get_reg(5'h10, 8'h81, 8'h81);
		repeat (200) @(posedge sys_clk_in);
		#1;
		chk1(irq, 1'b0);
	endtask
	// ceiling well above the roughly 600 cycles the tests need
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			stop_test();
		end
	end
	initial begin
		reset_dut();
		t_reset();
		t_latch();
		t_periodic();
		t_alarm();
		stop_test();
	end
endmodule
